// File: async_trace_pkg.sv
// Constants shared by the asynchronous trace output block
package async_trace_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [31:0] ADDR_STIM_BASE    = 32'he0000000;
	localparam logic [31:0] ADDR_TRACE_ENABLE = 32'he0000e00;
	localparam logic [31:0] ADDR_TRACE_PRIV   = 32'he0000e40;
	localparam logic [31:0] ADDR_TRACE_CTRL   = 32'he0000e80;
	localparam logic [31:0] ADDR_TRACE_STATUS = 32'he0000ef0;
	localparam logic [31:0] ADDR_TIMESTAMP    = 32'he0000ef4;
	localparam logic [31:0] ADDR_UNLOCK_KEY   = 32'he0000fb0;
	localparam logic [31:0] ADDR_DEBUG_MON    = 32'he000edfc;
	localparam logic [31:0] ADDR_PRESCALER    = 32'he0040010;
	localparam logic [31:0] ADDR_PIN_PROTO    = 32'he00400f0;
	localparam logic [31:0] ADDR_FLUSH_CTRL   = 32'he0040304;

	// ==========================================================
	// Fields and values
	localparam logic [31:0] UNLOCK_KEY        = 32'hc5acce55;
	localparam int          GLOBAL_EN_BIT     = 24;
	localparam int          CTRL_EN_BIT       = 0;
	localparam int          CTRL_TS_BIT       = 1;
	localparam int          CTRL_SYNC_BIT     = 2;
	localparam int          CTRL_SWO_BIT      = 4;
	localparam int          CTRL_ID_LSB       = 16;
	localparam int          ID_WIDTH          = 7;
	localparam logic [31:0] CTRL_MASK         = 32'h007f0017;
	localparam int          NUM_PORTS         = 32;
	localparam logic [1:0]  PROTO_MANCHESTER  = 2'h1;
	localparam logic [1:0]  PROTO_NRZ         = 2'h2;
	localparam logic [1:0]  PROTO_RESET       = 2'h1;
	localparam logic [31:0] FLUSH_RESET       = 32'h00000000;
	localparam int          PRESC_WIDTH       = 13;
	localparam logic [12:0] PRESC_RESET       = 13'h0000;

	// ==========================================================
	// Packet layout
	localparam int          TS_WIDTH          = 21;
	localparam int          ENTRY_WIDTH       = 60;
	localparam int          FIFO_DEPTH        = 4;
	localparam logic [7:0]  TS_HEADER         = 8'hc0;
	localparam logic [71:0] SYNC_BYTES        = 72'h000000800000000000;
	localparam logic [3:0]  SYNC_LEN          = 4'h6;
	localparam logic [3:0]  NRZ_BITS          = 4'ha;
	localparam logic [3:0]  MANCH_BITS        = 4'h9;

endpackage : async_trace_pkg

// File: async_trace_output.sv
// Trace source, packet FIFO and single-wire formatter with a Wishbone slave
`timescale 1ns/1ps

// ==========================================================
// Packet FIFO
module trace_fifo #(
	parameter int Width = 60,
	parameter int Depth = 4
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             inValid,
	output wire logic             inReady,
	input  wire logic [Width-1:0] inData,
	output wire logic             outValid,
	input  wire logic             outReady,
	output wire logic [Width-1:0] outData
);
	localparam int AW = $clog2(Depth);

	logic [Width-1:0] mem [Depth];
	logic [AW-1:0]    wrPtr_q;
	logic [AW-1:0]    rdPtr_q;
	logic [AW:0]      count_q;

	wire push = inValid & inReady;
	wire pop  = outValid & outReady;

	assign inReady  = (count_q != (AW+1)'(Depth));
	assign outValid = (count_q != '0);
	assign outData  = mem[rdPtr_q];

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
				wrPtr_q <= (wrPtr_q == AW'(Depth - 1)) ? '0 : wrPtr_q + 1'b1;
			if (pop)
				rdPtr_q <= (rdPtr_q == AW'(Depth - 1)) ? '0 : rdPtr_q + 1'b1;
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Storage carries no reset; only the pointers and the count define validity
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wrPtr_q] <= inData;
	end
endmodule : trace_fifo

// ==========================================================
// Top
// Contract
// - A 21-bit counter produces timestamps sent after each stimulus packet.
// - Trace unit configuration writes need the unlock key written first.
// - Control value 0x00010015 enables unit, sync, single-wire behaviour, source id 1.
// - Each trace enable bit enables its stimulus port; 0x1 enables port 0.
// - Privilege bit set restricts its port to privileged writes; clear allows user.
// - A stimulus port write is sent out as trace data through the formatter.
// - Formatter sends trace data at the core clock rate divided by the prescaler value plus one; Manchester bits take two such periods, halving it.
// - All trace data leaves on one pin shared with the scan data output.
// - Trace output only drives the pin when serial wire debug is selected.
// - Manchester and NRZ encodings exist; Manchester after reset.
// - Pin protocol value 0x2 selects NRZ output.
// - Trace works only while the global trace enable bit is set.
// - Prescaler value plus one divides the core clock into the output bit clock, setting the baud rate.
module async_trace_output (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [31:0] adr_i,
	input  wire logic [31:0] dat_i,
	output wire logic [31:0] dat_o,
	input  wire logic        we_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic        stb_i,
	input  wire logic        cyc_i,
	output wire logic        ack_o,
	input  wire logic        privAccess,
	input  wire logic        swdSelected,
	input  wire logic        tdoIn,
	input  wire logic        tdoOe,
	output wire logic        singleWireTracePinOut,
	output wire logic        singleWireTracePinOe,
	output wire logic [6:0]  traceSourceId
);
	// ==========================================================
	// Registers
	logic [31:0] ctrl_q;
	logic [31:0] enable_q;
	logic [31:0] priv_q;
	logic [31:0] demcr_q;
	logic [31:0] flush_q;
	logic [12:0] presc_q;
	logic [1:0]  proto_q;
	logic        unlocked_q;
	logic        ack_q;
	logic [31:0] rdata_q;
	logic [20:0] tsCount_q;
	logic [12:0] baudCnt_q;
	logic [71:0] pktVec_q;
	logic [3:0]  pktLeft_q;
	logic        syncPend_q;
	logic [9:0]  txShift_q;
	logic [3:0]  txBits_q;
	logic        txHalf_q;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : merge

	// ==========================================================
	// Decode
	wire        reqLive    = cyc_i & stb_i & ~ack_q;
	wire        hitStim    = (adr_i[31:7] == async_trace_pkg::ADDR_STIM_BASE[31:7]);
	wire        hitEnable  = (adr_i == async_trace_pkg::ADDR_TRACE_ENABLE);
	wire        hitPriv    = (adr_i == async_trace_pkg::ADDR_TRACE_PRIV);
	wire        hitCtrl    = (adr_i == async_trace_pkg::ADDR_TRACE_CTRL);
	wire        hitStatus  = (adr_i == async_trace_pkg::ADDR_TRACE_STATUS);
	wire        hitTs      = (adr_i == async_trace_pkg::ADDR_TIMESTAMP);
	wire        hitUnlock  = (adr_i == async_trace_pkg::ADDR_UNLOCK_KEY);
	wire        hitDemcr   = (adr_i == async_trace_pkg::ADDR_DEBUG_MON);
	wire        hitPresc   = (adr_i == async_trace_pkg::ADDR_PRESCALER);
	wire        hitProto   = (adr_i == async_trace_pkg::ADDR_PIN_PROTO);
	wire        hitFlush   = (adr_i == async_trace_pkg::ADDR_FLUSH_CTRL);
	wire [4:0]  stimPort   = adr_i[6:2];

	wire        globalEn   = demcr_q[async_trace_pkg::GLOBAL_EN_BIT];
	wire        unitEn     = globalEn & ctrl_q[async_trace_pkg::CTRL_EN_BIT];
	wire        tsEn       = ctrl_q[async_trace_pkg::CTRL_TS_BIT];
	wire        syncEn     = ctrl_q[async_trace_pkg::CTRL_SYNC_BIT];
	wire        swoMode    = ctrl_q[async_trace_pkg::CTRL_SWO_BIT];
	wire        nrzMode    = (proto_q == async_trace_pkg::PROTO_NRZ);

	// ==========================================================
	// Stimulus intake
	wire        portOpen   = enable_q[stimPort] & (privAccess | ~priv_q[stimPort]);
	wire        stimAccept = reqLive & we_i & hitStim & unitEn & portOpen;
	wire        fifoInReady;
	wire        fifoOutValid;
	wire        fifoOutReady;
	wire [59:0] fifoOut;

	// Back-pressure: a stimulus write waits for room rather than dropping data
	wire        ackNext    = reqLive & ~(stimAccept & ~fifoInReady);
	wire        wrNow      = ackNext & we_i;
	wire        cfgWr      = wrNow & unlocked_q;

	wire [1:0]  sizeCode   = (sel_i == 4'h1) ? 2'h1 : (sel_i == 4'h3) ? 2'h2 : 2'h3;
	wire [31:0] stimData   = (sel_i == 4'h1) ? {24'h000000, dat_i[7:0]} :
	                         (sel_i == 4'h3) ? {16'h0000, dat_i[15:0]} : dat_i;
	wire [59:0] fifoIn     = {tsCount_q, sizeCode, stimPort, stimData};

	trace_fifo #(
		.Width (async_trace_pkg::ENTRY_WIDTH),
		.Depth (async_trace_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.reset    (reset),
		.inValid  (stimAccept),
		.inReady  (fifoInReady),
		.inData   (fifoIn),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOut)
	);

	// ==========================================================
	// Packet building
	wire [20:0] eTs        = fifoOut[59:39];
	wire [1:0]  eSize      = fifoOut[38:37];
	wire [4:0]  ePort      = fifoOut[36:32];
	wire [2:0]  eBytes     = (eSize == 2'h3) ? 3'h4 : {1'b0, eSize};
	wire [7:0]  eHeader    = {ePort, 1'b0, eSize};
	wire [31:0] tsBytes    = {1'b0, eTs[20:14], 1'b1, eTs[13:7], 1'b1, eTs[6:0], async_trace_pkg::TS_HEADER};
	wire [6:0]  tsShift    = {1'b0, eBytes, 3'h0} + 7'h08;
	wire [71:0] tsPlaced   = tsEn ? ({40'h0, tsBytes} << tsShift) : 72'h0;
	wire [71:0] loadVec    = {32'h0, fifoOut[31:0], eHeader} | tsPlaced;
	wire [3:0]  loadLen    = 4'h1 + {1'b0, eBytes} + (tsEn ? 4'h4 : 4'h0);
	wire        pktIdle    = (pktLeft_q == 4'h0);
	assign fifoOutReady    = pktIdle & ~syncPend_q;

	// ==========================================================
	// Bit clock and serializer
	// Bit rate follows the prescaler only, not the core rate of any consumer
	wire        baudTick   = (baudCnt_q == presc_q);
	wire        txIdle     = (txBits_q == 4'h0);
	wire        loadByte   = baudTick & txIdle & ~pktIdle;
	wire        ctrlWrite  = cfgWr & hitCtrl;
	wire [31:0] prescNext  = merge({19'h0, presc_q}, dat_i, sel_i);
	wire [31:0] ctrlNext   = merge(ctrl_q, dat_i, sel_i) & async_trace_pkg::CTRL_MASK;
	wire        syncStart  = ctrlWrite & ctrlNext[async_trace_pkg::CTRL_EN_BIT] &
	                         ctrlNext[async_trace_pkg::CTRL_SYNC_BIT] & ~ctrl_q[async_trace_pkg::CTRL_EN_BIT];
	wire        tsStep     = swoMode ? baudTick : 1'b1;

	// Manchester: each bit is two ticks, first half carries the bit value
	wire        lineLevel  = nrzMode ? (txIdle ? 1'b1 : txShift_q[0]) :
	                         (txIdle ? 1'b0 : (txShift_q[0] ^ txHalf_q));

	// ==========================================================
	// Pin sharing: scan data output keeps the pin unless serial wire debug
	assign singleWireTracePinOut = swdSelected ? lineLevel : tdoIn;
	assign singleWireTracePinOe  = swdSelected ? globalEn : tdoOe;
	assign traceSourceId         = ctrl_q[async_trace_pkg::CTRL_ID_LSB +: async_trace_pkg::ID_WIDTH];

	// ==========================================================
	// Read mux
	wire [31:0] statusWord = {29'h0, fifoOutValid, unlocked_q, ~(pktIdle & txIdle & ~fifoOutValid)};
	wire [31:0] readWord   = hitCtrl   ? ctrl_q   :
	                         hitEnable ? enable_q :
	                         hitPriv   ? priv_q   :
	                         hitDemcr  ? demcr_q  :
	                         hitPresc  ? {19'h0, presc_q} :
	                         hitProto  ? {30'h0, proto_q} :
	                         hitFlush  ? flush_q  :
	                         hitStatus ? statusWord :
	                         hitTs     ? {11'h0, tsCount_q} : 32'h0;

	assign ack_o = ack_q;
	assign dat_o = rdata_q;

	// ==========================================================
	// Bus slave and configuration
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ack_q      <= 1'b0;
			rdata_q    <= 32'h0;
			unlocked_q <= 1'b0;
			ctrl_q     <= 32'h0;
			enable_q   <= 32'h0;
			priv_q     <= 32'h0;
			demcr_q    <= 32'h0;
			presc_q    <= async_trace_pkg::PRESC_RESET;
			proto_q    <= async_trace_pkg::PROTO_RESET;
			flush_q    <= async_trace_pkg::FLUSH_RESET;
		end
		else
		begin
			ack_q <= ackNext;
			if (ackNext)
				rdata_q <= we_i ? 32'h0 : readWord;
			if (wrNow & hitUnlock)
				unlocked_q <= (dat_i == async_trace_pkg::UNLOCK_KEY);
			if (ctrlWrite)
				ctrl_q <= ctrlNext;
			if (cfgWr & hitEnable)
				enable_q <= merge(enable_q, dat_i, sel_i);
			if (cfgWr & hitPriv)
				priv_q <= merge(priv_q, dat_i, sel_i);
			if (wrNow & hitDemcr)
				demcr_q <= merge(demcr_q, dat_i, sel_i);
			if (wrNow & hitPresc)
				presc_q <= prescNext[12:0];
			if (wrNow & hitProto & sel_i[0])
				proto_q <= dat_i[1:0];
			if (wrNow & hitFlush)
				flush_q <= merge(flush_q, dat_i, sel_i);
		end
	end

	// ==========================================================
	// Timestamp counter, saturating, restarted at each captured packet
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			tsCount_q <= 21'h0;
		else if (stimAccept & fifoInReady)
			tsCount_q <= 21'h0;
		else if (unitEn & tsStep & (tsCount_q != 21'h1fffff))
			tsCount_q <= tsCount_q + 21'h1;
	end

	// ==========================================================
	// Packet sequencer
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pktVec_q   <= 72'h0;
			pktLeft_q  <= 4'h0;
			syncPend_q <= 1'b0;
		end
		else
		begin
			if (pktIdle & syncPend_q)
			begin
				pktVec_q   <= async_trace_pkg::SYNC_BYTES;
				pktLeft_q  <= async_trace_pkg::SYNC_LEN;
				syncPend_q <= 1'b0;
			end
			else if (pktIdle & fifoOutValid)
			begin
				pktVec_q  <= loadVec;
				pktLeft_q <= loadLen;
			end
			else if (loadByte)
			begin
				pktVec_q  <= pktVec_q >> 8;
				pktLeft_q <= pktLeft_q - 4'h1;
			end
			// A new enable in the same cycle as a load still queues its sync
			if (syncStart)
				syncPend_q <= 1'b1;
		end
	end

	// ==========================================================
	// Serializer
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			baudCnt_q <= 13'h0;
			txShift_q <= 10'h0;
			txBits_q  <= 4'h0;
			txHalf_q  <= 1'b0;
		end
		else
		begin
			baudCnt_q <= baudTick ? 13'h0 : baudCnt_q + 13'h1;
			if (loadByte)
			begin
				txShift_q <= nrzMode ? {1'b1, pktVec_q[7:0], 1'b0} : {1'b0, pktVec_q[7:0], 1'b1};
				txBits_q  <= nrzMode ? async_trace_pkg::NRZ_BITS : async_trace_pkg::MANCH_BITS;
				txHalf_q  <= 1'b0;
			end
			else if (baudTick & ~txIdle)
			begin
				if (nrzMode | txHalf_q)
				begin
					txShift_q <= txShift_q >> 1;
					txBits_q  <= txBits_q - 4'h1;
					txHalf_q  <= 1'b0;
				end
				else
					txHalf_q <= 1'b1;
			end
		end
	end
endmodule : async_trace_output

// File: async_trace_output_chk.sv
// Concurrent checks on the ports of the asynchronous trace output block
`timescale 1ns/1ps
module async_trace_output_chk (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic [31:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        we_i,
	input wire logic [3:0]  sel_i,
	input wire logic        stb_i,
	input wire logic        cyc_i,
	input wire logic        ack_o,
	input wire logic        privAccess,
	input wire logic        swdSelected,
	input wire logic        tdoIn,
	input wire logic        tdoOe,
	input wire logic        singleWireTracePinOut,
	input wire logic        singleWireTracePinOe,
	input wire logic [6:0]  traceSourceId
);
	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Stimulus writes may stall on a full FIFO, so only register accesses have a fixed latency
	wire regReq = cyc_i && stb_i && !ack_o && adr_i[31:7] != async_trace_pkg::ADDR_STIM_BASE[31:7];
	a_scan_oe_pass: assert property (!swdSelected |-> singleWireTracePinOe == tdoOe)
		else $error("pin enable not taken from scan port");
	a_scan_pin_pass: assert property (!swdSelected |-> singleWireTracePinOut == tdoIn)
		else $error("pin level not taken from scan port");
	a_id_on_write: assert property ($changed(traceSourceId) |-> ack_o && we_i && adr_i == async_trace_pkg::ADDR_TRACE_CTRL)
		else $error("source id changed without a control write");
	a_key_reads_zero: assert property (ack_o && !we_i && adr_i == async_trace_pkg::ADDR_UNLOCK_KEY |-> dat_o == 32'h0)
		else $error("unlock key read back non-zero");
	a_reg_ack_next: assert property (regReq |=> ack_o)
		else $error("register access not acknowledged next cycle");
	a_ack_one_cycle: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_has_req: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	a_write_data_zero: assert property (ack_o && we_i |-> dat_o == 32'h0)
		else $error("read data not zero on write ack");
	c_ctrl_write: cover property (ack_o && we_i && adr_i == async_trace_pkg::ADDR_TRACE_CTRL);
	c_stim_write: cover property (ack_o && we_i && adr_i == async_trace_pkg::ADDR_STIM_BASE);
	c_scan_mode: cover property (!swdSelected && tdoOe);
endmodule : async_trace_output_chk

bind async_trace_output async_trace_output_chk async_trace_output_chk_i (.clk(clk), .reset(reset), .adr_i(adr_i),
	.dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i), .ack_o(ack_o),
	.privAccess(privAccess), .swdSelected(swdSelected), .tdoIn(tdoIn), .tdoOe(tdoOe),
	.singleWireTracePinOut(singleWireTracePinOut), .singleWireTracePinOe(singleWireTracePinOe),
	.traceSourceId(traceSourceId));

// File: trace_probe.sv
// Debug probe model that captures NRZ bytes from the single-wire trace pin
`timescale 1ns/1ps
module trace_probe #(
	parameter int BitCycles = 4
) (
	input wire logic clk,
	input wire logic pin,
	input wire logic oe
);
	// ==========================================================
	// Receiver
	logic [7:0] rxq[$];
	int         frameErr = 0;
	// Samples mid-bit; a start is only trusted while the pin is driven
	initial
	begin
		logic [7:0] b;
		forever
		begin
			@(posedge clk);
			if (oe === 1'b1 && pin === 1'b0)
			begin
				repeat (BitCycles / 2) @(posedge clk);
				for (int i = 0; i < 8; i++)
				begin
					repeat (BitCycles) @(posedge clk);
					b[i] = pin;
				end
				repeat (BitCycles) @(posedge clk);
				if (pin !== 1'b1)
					frameErr++;
				rxq.push_back(b);
			end
		end
	end
endmodule : trace_probe

// File: testbench.sv
// Self-checking bench for the asynchronous trace output block
`timescale 1ns/1ps
module testbench;
	// ==========================================================
	// Signals
	logic        clk, reset = 1'b1, we = 1'b0, stb = 1'b0, cyc = 1'b0, ack, pinOut, pinOe;
	logic        priv = 1'b1, swd = 1'b1, tdoIn = 1'b0, tdoOe = 1'b0;
	logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, dat;
	logic [3:0]  sel = 4'h0;
	logic [6:0]  srcId;
	logic [7:0]  expq[$];
	int          err_total = 0, num_checks = 0;

	async_trace_output async_trace_output_i (.clk(clk), .reset(reset), .adr_i(adr), .dat_i(wdat), .dat_o(dat),
		.we_i(we), .sel_i(sel), .stb_i(stb), .cyc_i(cyc), .ack_o(ack), .privAccess(priv), .swdSelected(swd),
		.tdoIn(tdoIn), .tdoOe(tdoOe), .singleWireTracePinOut(pinOut), .singleWireTracePinOe(pinOe),
		.traceSourceId(srcId));
	// Prescaler 3 gives four clocks per bit
	trace_probe #(.BitCycles(4)) probe_i (.clk(clk), .pin(pinOut), .oe(pinOe));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================================
	// Tasks
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Classic single cycle; holds everything until ack is sampled
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 3000);
		rdat = dat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 3000)
			chk(32'h0, 32'h1);
	endtask : wb

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hf);
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0, 4'hf);
		chk(rdat, exp);
	endtask : rd

	// ==========================================================
	// Tests
	initial
	begin
		int i;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		rd(async_trace_pkg::ADDR_PIN_PROTO, {30'h0, async_trace_pkg::PROTO_RESET});
		chk(pinOut, 1'b0);
		rd(32'he0001000, 32'h0);
		// Formatter first; the probe only listens once the pin is enabled
		wr(async_trace_pkg::ADDR_PIN_PROTO, 32'h2);
		rd(async_trace_pkg::ADDR_PIN_PROTO, 32'h2);
		wr(async_trace_pkg::ADDR_PRESCALER, 32'h3);
		wr(async_trace_pkg::ADDR_FLUSH_CTRL, 32'h100);
		rd(async_trace_pkg::ADDR_FLUSH_CTRL, 32'h100);
		wr(async_trace_pkg::ADDR_DEBUG_MON, 32'h01000000);
		rd(async_trace_pkg::ADDR_DEBUG_MON, 32'h01000000);
		wr(async_trace_pkg::ADDR_TRACE_CTRL, 32'h00010015);
		rd(async_trace_pkg::ADDR_TRACE_CTRL, 32'h0);
		wr(async_trace_pkg::ADDR_UNLOCK_KEY, async_trace_pkg::UNLOCK_KEY);
		rd(async_trace_pkg::ADDR_UNLOCK_KEY, 32'h0);
		wr(async_trace_pkg::ADDR_TRACE_CTRL, 32'h00010015);
		rd(async_trace_pkg::ADDR_TRACE_CTRL, 32'h00010015);
		chk(srcId, 32'h1);
		expq = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80};
		wr(async_trace_pkg::ADDR_TRACE_ENABLE, 32'h1);
		wr(async_trace_pkg::ADDR_TRACE_PRIV, 32'h1);
		priv <= 1'b0;
		wb(1'b1, async_trace_pkg::ADDR_STIM_BASE, 32'ha5, 4'h1);
		priv <= 1'b1;
		wb(1'b1, async_trace_pkg::ADDR_STIM_BASE + 32'h4, 32'h66, 4'h1);
		wb(1'b1, async_trace_pkg::ADDR_STIM_BASE, 32'h3c, 4'h1);
		wb(1'b1, async_trace_pkg::ADDR_STIM_BASE, 32'h1234, 4'h3);
		wb(1'b1, async_trace_pkg::ADDR_STIM_BASE, 32'h89abcdef, 4'hf);
		expq = {expq, 8'h01, 8'h3c, 8'h02, 8'h34, 8'h12, 8'h03, 8'hef, 8'hcd, 8'hab, 8'h89};
		// Back to back writes overrun the FIFO and must stall the bus, not drop data
		for (i = 0; i < 6; i++)
		begin
			wb(1'b1, async_trace_pkg::ADDR_STIM_BASE, 32'h40 + i, 4'h1);
			expq = {expq, 8'h01, 8'h40 + 8'(i)};
		end
		i = 0;
		while (probe_i.rxq.size() < expq.size() && i < 20000)
		begin
			@(posedge clk);
			i++;
		end
		repeat (200) @(posedge clk);
		chk(probe_i.rxq.size(), expq.size());
		for (i = 0; i < expq.size() && i < probe_i.rxq.size(); i++)
			chk(probe_i.rxq[i], expq[i]);
		chk(probe_i.frameErr, 32'h0);
		chk(pinOut, 1'b1);
		wr(async_trace_pkg::ADDR_DEBUG_MON, 32'h0);
		chk(pinOe, 1'b0);
		wb(1'b1, async_trace_pkg::ADDR_STIM_BASE, 32'h77, 4'h1);
		wr(async_trace_pkg::ADDR_DEBUG_MON, 32'h01000000);
		repeat (300) @(posedge clk);
		chk(probe_i.rxq.size(), expq.size());
		swd <= 1'b0;
		for (i = 0; i < 4; i++)
		begin
			@(posedge clk);
			{tdoIn, tdoOe} <= 2'(i);
			@(posedge clk);
			chk(pinOut, tdoIn);
			chk(pinOe, tdoOe);
		end
		tally_and_finish;
	end

	// Whole sequence needs a few thousand cycles
	initial
	begin
		repeat (40000) @(posedge clk);
		err_total++;
		$display("ERROR %0t: watchdog expired", $time);
		tally_and_finish;
	end
endmodule : testbench
